/* logic/dcgm_pkg.sv */
// Purpose: constants and types for the dual channel guard monitor
// Assumes: 125 MHz clock, inputs synchronous to clk
// Notes: beam count and long timeouts are parameters of the top module
// Behaviour
// - single channel failure drops outputs, locks reset
// - either channel opening drops safety outputs
// - reclosed without both opening: refuse reset
// - both opened then closed: mismatch cleared
// - synchronization beam never blanked
// - one clear beam between blanked areas
// - blanked beam clearing drops outputs
// - remote teach affects only this receiver
// - standalone works without cascade setup
// - teach unfinished in ten minutes locks out
// - after teach: trip on, latch awaits reset (code: trip stays off while a channel is open or the open records differ)
package dcgm_pkg;
    localparam int CLK_MHZ = 125;
    localparam int TEACH_HOLD_MS = 250;
    localparam int TEACH_HOLD_CYC = TEACH_HOLD_MS * 1000 * CLK_MHZ;
    localparam longint TEACH_TIMEOUT_MIN = 10;
    localparam longint TEACH_TIMEOUT_CYC = TEACH_TIMEOUT_MIN * 60 * 1000000 * CLK_MHZ;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_TEACH_TIMEOUT = 8'h0C;
    localparam logic [7:0] ERR_BLANK_LAYOUT = 8'h0D;
    typedef enum {
        DCGM_RUN,
        DCGM_TRIP,
        DCGM_TEACH,
        DCGM_LOCK
    } dcgm_state_t;
endpackage

/* logic/dcgm_top.sv */
// Purpose: receiver safety logic: guard channels, blanking check, remote teach
// Assumes: all inputs synchronous to clk; beam bit 0 is the sync beam
// Notes: lockout here is a teach timeout or bad blanking layout, left by power cycle
`timescale 1ns/100ps
module dcgm_top #(
    parameter int BEAMS = 16,
    parameter longint TIMEOUT_CYC = dcgm_pkg::TEACH_TIMEOUT_CYC,
    parameter int HOLD_CYC = dcgm_pkg::TEACH_HOLD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // guard channels, high while closed
    input wire logic guard_channel_one_a,
    input wire logic guard_channel_two_a,
    // beams, high while blocked
    input wire logic [BEAMS-1:0] beam_blocked,
    // operator switches
    input wire logic reset_switch,
    input wire logic program_switch,
    input wire logic latch_mode,
    // results
    output logic safety_output_pair,
    output logic reset_locked,
    output logic teach_active,
    output logic [7:0] error_code,
    output logic [BEAMS-1:0] blank_map
);
    dcgm_pkg::dcgm_state_t state_r;
    logic ch1_opened_r; // channel one seen open since last reset
    logic ch2_opened_r;
    logic both_closed;
    logic reset_ok; // both channels cycled, reset allowed
    logic reset_d_r; // previous reset_switch level
    logic reset_rise;
    logic prog_d_r;
    logic prog_fall;
    logic [31:0] hold_cnt_r;
    logic hold_done;
    logic [63:0] teach_cnt_r;
    logic [BEAMS-1:0] blank_map_r;
    logic blank_fault; // a blanked beam went clear
    logic layout_bad; // taught pattern breaks layout limits
    logic [BEAMS-1:0] cand;
    logic reset_accept; // tripped state may come back on this cycle

    assign both_closed = guard_channel_one_a & guard_channel_two_a;
    // reset needs both channels to have opened since the last accepted reset
    assign reset_ok = ch1_opened_r & ch2_opened_r & both_closed;
    assign reset_rise = reset_switch & ~reset_d_r;
    assign prog_fall = prog_d_r & ~program_switch;
    assign hold_done = (hold_cnt_r >= 32'(HOLD_CYC));
    // any taught beam seen clear is a break of the field
    assign blank_fault = |(blank_map_r & ~beam_blocked);
    assign cand = beam_blocked;
    // a contiguous run of blocked beams is one area, so any two areas
    // are always split by at least one clear beam with no further check
    // the sync beam must stay clear when a pattern is taught
    assign layout_bad = cand[0];
    // one condition drives both the state change and the record clear, so the
    // records are wiped in trip mode too, where no key press is ever seen
    assign reset_accept = (state_r == dcgm_pkg::DCGM_TRIP) && !program_switch && reset_ok
        && !blank_fault && (reset_rise || !latch_mode);

    // edge detectors for switches
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reset_d_r <= 1'b0;
            prog_d_r <= 1'b0;
        end
        else
        begin
            reset_d_r <= reset_switch;
            prog_d_r <= program_switch;
        end
    end

    // per-channel open record; set beats the clear on reset acceptance
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ch1_opened_r <= 1'b0;
            ch2_opened_r <= 1'b0;
        end
        else
        begin
            if (!guard_channel_one_a)
                ch1_opened_r <= 1'b1;
            else if (reset_accept)
                ch1_opened_r <= 1'b0;
            if (!guard_channel_two_a)
                ch2_opened_r <= 1'b1;
            else if (reset_accept)
                ch2_opened_r <= 1'b0;
        end
    end

    // program key hold timer, counts only while key is in program
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hold_cnt_r <= 32'h0000_0000;
        else if (!program_switch)
            hold_cnt_r <= 32'h0000_0000;
        else if (!hold_done)
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
    end

    // teach session timer, saturates at the timeout
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            teach_cnt_r <= 64'h0000_0000_0000_0000;
        else if (state_r != dcgm_pkg::DCGM_TEACH)
            teach_cnt_r <= 64'h0000_0000_0000_0000;
        else if (teach_cnt_r < 64'(TIMEOUT_CYC))
            teach_cnt_r <= teach_cnt_r + 64'h0000_0000_0000_0001;
    end

    // main state: run, tripped, teaching, locked out
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= dcgm_pkg::DCGM_TRIP; // powers up off; standalone needs no setup
            blank_map_r <= '0;
            error_code <= dcgm_pkg::ERR_NONE;
        end
        else
        begin
            case (state_r)
                dcgm_pkg::DCGM_RUN:
                begin
                    if (program_switch)
                        state_r <= dcgm_pkg::DCGM_TEACH;
                    // either channel alone trips
                    else if (!both_closed || blank_fault)
                        state_r <= dcgm_pkg::DCGM_TRIP;
                end
                dcgm_pkg::DCGM_TRIP:
                begin
                    if (program_switch)
                        state_r <= dcgm_pkg::DCGM_TEACH;
                    else if (reset_accept)
                        state_r <= dcgm_pkg::DCGM_RUN;
                end
                dcgm_pkg::DCGM_TEACH:
                begin
                    // only this receiver's map is written
                    if (teach_cnt_r >= 64'(TIMEOUT_CYC))
                    begin
                        state_r <= dcgm_pkg::DCGM_LOCK;
                        error_code <= dcgm_pkg::ERR_TEACH_TIMEOUT;
                    end
                    else if (prog_fall && layout_bad)
                    begin
                        state_r <= dcgm_pkg::DCGM_LOCK;
                        error_code <= dcgm_pkg::ERR_BLANK_LAYOUT;
                    end
                    else if (prog_fall)
                    begin
                        blank_map_r <= cand;
                        // trip mode comes straight on, latch waits for reset
                        // a half-cycled guard keeps its lockout, teaching is no way round it
                        if (!latch_mode && both_closed && (ch1_opened_r == ch2_opened_r))
                            state_r <= dcgm_pkg::DCGM_RUN;
                        else
                            state_r <= dcgm_pkg::DCGM_TRIP;
                    end
                end
                dcgm_pkg::DCGM_LOCK:
                    state_r <= dcgm_pkg::DCGM_LOCK; // held until power cycle
                default:
                    state_r <= dcgm_pkg::DCGM_TRIP;
            endcase
        end
    end

    assign safety_output_pair = (state_r == dcgm_pkg::DCGM_RUN);
    assign reset_locked = !reset_ok || (state_r == dcgm_pkg::DCGM_LOCK);
    assign teach_active = (state_r == dcgm_pkg::DCGM_TEACH);
    assign blank_map = blank_map_r;

    // checks
    chan_open_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (!guard_channel_one_a || !guard_channel_two_a) |=> !safety_output_pair)
        else $error("channel open but outputs stayed on");
    blank_clear_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (safety_output_pair && blank_fault && !program_switch) |=> !safety_output_pair)
        else $error("blanked beam clear but outputs on");
    no_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        ($rose(safety_output_pair) && $past(state_r) == dcgm_pkg::DCGM_TRIP)
        |-> $past(reset_ok))
        else $error("reset accepted without both channels cycled");
    record_clr_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(ch1_opened_r) |-> $past(state_r) == dcgm_pkg::DCGM_TRIP)
        else $error("open record cleared outside reset");
    sync_free_a: assert property (@(posedge clk) disable iff (!rstn)
        !blank_map_r[0])
        else $error("sync beam blanked");
    timeout_lock_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == dcgm_pkg::DCGM_TEACH && teach_cnt_r >= 64'(TIMEOUT_CYC))
        |=> state_r == dcgm_pkg::DCGM_LOCK && error_code == dcgm_pkg::ERR_TEACH_TIMEOUT)
        else $error("teach timeout missed");
    latch_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == dcgm_pkg::DCGM_TEACH && prog_fall && latch_mode)
        |=> !safety_output_pair)
        else $error("latch mode turned on without reset");
    mismatch_lock_a: assert property (@(posedge clk) disable iff (!rstn)
        (!ch1_opened_r || !ch2_opened_r) |-> reset_locked)
        else $error("reset allowed with channel mismatch");
    teach_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == dcgm_pkg::DCGM_TEACH && prog_fall && (ch1_opened_r != ch2_opened_r))
        |=> !safety_output_pair)
        else $error("teach turned outputs on over a channel mismatch");
    run_c: cover property (@(posedge clk) disable iff (!rstn) $rose(safety_output_pair));
    trip_auto_c: cover property (@(posedge clk) disable iff (!rstn) reset_accept && !latch_mode);
    teach_c: cover property (@(posedge clk) disable iff (!rstn)
        state_r == dcgm_pkg::DCGM_TEACH ##1 state_r == dcgm_pkg::DCGM_RUN);
    lock_c: cover property (@(posedge clk) disable iff (!rstn) $rose(state_r == dcgm_pkg::DCGM_LOCK));
endmodule

/* tb/dcgm_partner.sv */
// Purpose: far-side switches: two guard contacts, reset key, program key
// Assumes: the bench calls the tasks just after a falling clock edge
// Notes: plain levels, no contact bounce is modelled
`timescale 1ns/100ps
module dcgm_partner (
    // guard contacts, high while closed
    output logic ch_one,
    output logic ch_two,
    // operator keys
    output logic reset_sw,
    output logic prog_sw
);
    // guards shut and keys at rest from power-up
    initial
    begin
        ch_one = 1'b1;
        ch_two = 1'b1;
        reset_sw = 1'b0;
        prog_sw = 1'b0;
    end
    // each contact moves on its own, so a stuck switch can be mimicked
    task automatic set_sw(input logic a, input logic b, input logic r, input logic p);
        ch_one = a;
        ch_two = b;
        reset_sw = r;
        prog_sw = p;
    endtask
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the guard monitor in latch and trip modes
// Assumes: 125 MHz clock, inputs driven on the falling edge
// Notes: latch mode first, trip mode last; the teach timeout is shortened to 200 cycles
`timescale 1ns/100ps
module tb_top;
    localparam int NB = 8;
    localparam int TMO = 200;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ch1, ch2, rsw, psw;
    logic [NB-1:0] beams = '0;
    logic out, lockd, teach;
    logic [7:0] err;
    logic [NB-1:0] map;
    // behavioural model state
    int bad_count = 0;
    int checks_done = 0;
    int r1, r2, m_out, m_lock, m_err, m_map, prs, ppg, pcnt;
    logic [31:0] seed = 32'he4ae_be25;
    logic [NB-1:0] pat;
    logic latch = 1'b1; // output mode pin, latch until the last test
    // 125 MHz clock
    always #4 clk = ~clk;
    dcgm_partner sw (.ch_one(ch1), .ch_two(ch2), .reset_sw(rsw), .prog_sw(psw));
    dcgm_top #(.BEAMS(NB), .TIMEOUT_CYC(TMO), .HOLD_CYC(4)) dut (.clk(clk), .rstn(rstn),
        .guard_channel_one_a(ch1), .guard_channel_two_a(ch2), .beam_blocked(beams),
        .reset_switch(rsw), .program_switch(psw), .latch_mode(latch),
        .safety_output_pair(out), .reset_locked(lockd), .teach_active(teach),
        .error_code(err), .blank_map(map));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one clock of the model, then all five outputs are compared once settled
    task automatic tick();
        @(posedge clk);
        if (!ch1) r1 = 1;
        if (!ch2) r2 = 1;
        if (psw)
        begin
            pcnt++;
            m_out = 0;
            // teach starts one edge after the key is seen, the lock one edge after the count
            if (pcnt >= TMO + 2 && !m_lock)
            begin
                m_lock = 1;
                m_err = 8'h0C;
            end
        end
        else if (ppg && !m_lock)
        begin
            // a blocked sync beam cannot be taught
            if (beams[0])
            begin
                m_lock = 1;
                m_err = 8'h0D;
            end
            else
            begin
                m_map = beams;
                // trip mode comes straight on unless the channel records disagree
                m_out = !latch && ch1 && ch2 && r1 == r2;
            end
        end
        else if (m_out && (!ch1 || !ch2 || (beams & m_map) != m_map)) m_out = 0;
        else if (!m_out && !m_lock && r1 && r2 && ch1 && ch2 && (beams & m_map) == m_map
            && ((rsw && !prs) || !latch))
        begin
            m_out = 1;
            r1 = 0;
            r2 = 0;
        end
        if (!psw) pcnt = 0;
        ppg = psw;
        prs = rsw;
        #1;
        chk("safety_output_pair", out, m_out);
        chk("reset_locked", lockd, m_lock || !(r1 && r2 && ch1 && ch2));
        chk("teach_active", teach, psw && !m_lock);
        chk("error_code", err, m_err);
        chk("blank_map", map, m_map);
    endtask
    task automatic drv(input logic a, b, r, p, input logic [NB-1:0] bm, input int n);
        @(negedge clk);
        sw.set_sw(a, b, r, p);
        beams = bm;
        repeat (n) tick();
    endtask
    task automatic do_reset();
        @(negedge clk);
        rstn = 1'b0;
        r1 = 0;
        r2 = 0;
        m_out = 0;
        m_lock = 0;
        m_err = 0;
        m_map = 0;
        prs = 0;
        ppg = 0;
        pcnt = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
    endtask
    task automatic cycle_press(input logic [NB-1:0] bm);
        drv(0, 0, 0, 0, bm, 2);
        drv(1, 1, 0, 0, bm, 2);
        drv(1, 1, 1, 0, bm, 2);
        drv(1, 1, 0, 0, bm, 2);
    endtask
    // hang guard
    initial
    begin
        #400000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        do_reset();
        chk("reset_locked", lockd, 1);
        chk("error_code", err, 8'h00);
        cycle_press('0);
        chk("safety_output_pair", out, 1);
        $display("test standalone start done");
        // one contact stuck shut, then the other
        for (int k = 0; k < 2; k++)
        begin
            drv(k[0], !k[0], 0, 0, '0, 3);
            drv(1, 1, 0, 0, '0, 3);
            chk("reset_locked", lockd, 1);
            drv(1, 1, 1, 0, '0, 2);
            drv(1, 1, 0, 0, '0, 2);
            cycle_press('0);
        end
        $display("test stuck contact done");
        seed = xs(seed);
        pat = seed[NB-1:0] & 8'hFE | 8'h02;
        drv(0, 0, 0, 0, pat, 2);
        drv(1, 1, 0, 1, pat, 6);
        drv(1, 1, 0, 0, pat, 3);
        chk("blank_map", map, pat);
        drv(1, 1, 1, 0, pat, 2);
        drv(1, 1, 0, 0, pat, 2);
        chk("safety_output_pair", out, 1);
        drv(1, 1, 0, 0, pat & 8'hFD, 3);
        chk("safety_output_pair", out, 0);
        $display("test teach and blanking done");
        drv(0, 0, 0, 0, pat | 8'h01, 2);
        drv(1, 1, 0, 1, pat | 8'h01, 6);
        drv(1, 1, 0, 0, pat | 8'h01, 3);
        chk("error_code", err, 8'h0D);
        chk("blank_map bit0", map[0], 0);
        do_reset();
        drv(1, 1, 0, 1, '0, TMO + 20);
        chk("error_code", err, 8'h0C);
        chk("reset_locked", lockd, 1);
        $display("test lockouts done");
        // trip mode: no key press, turn-on as soon as both channels have cycled
        do_reset();
        latch = 1'b0;
        drv(0, 1, 0, 0, '0, 2);
        drv(1, 0, 0, 0, '0, 2);
        drv(1, 1, 0, 0, '0, 2);
        chk("safety_output_pair", out, 1);
        drv(0, 1, 0, 0, '0, 2);
        drv(1, 1, 0, 0, '0, 3);
        chk("safety_output_pair", out, 0);
        drv(1, 1, 0, 1, pat, 6);
        drv(1, 1, 0, 0, pat, 2);
        chk("safety_output_pair", out, 0);
        drv(1, 0, 0, 0, pat, 2);
        drv(1, 1, 0, 0, pat, 2);
        chk("safety_output_pair", out, 1);
        drv(1, 1, 0, 1, pat, 6);
        drv(1, 1, 0, 0, pat, 2);
        chk("safety_output_pair", out, 1);
        $display("test trip mode done");
        give_verdict();
    end
endmodule
